// >>> rtl/bstap_port.sv
`timescale 1ns/1ns
// Operation
// - all inputs are sampled on the rising test-clock edge only
// - serial output changes only on the falling test-clock edge
// - mode-select commands the controller, sampled at each rising edge
// - open mode-select line reads high
// - open data input reads high
// - serial input enters the MSB of the selected register
// - serial output comes from the LSB of the selected register
// - instruction register chooses the register in the scan path
// - output driver enabled only in the shift states
// - controller, instruction, boundary, bypass and identification registers
// - controller and instructions follow the boundary-scan standard
// - test logic runs on the system clock, stepped by synchronised test-clock edges
// - power-up puts the port into reset without disturbing memory
// - five high mode-select rising edges reset the test port
// - three-bit instruction register loads identification code on reset
// - capture-IR loads 01 into the two instruction LSBs
// - serial output is high impedance after power-up
module bstap_port #(
  parameter int BSR_LEN = bstap_pkg::BSR_LEN_DEF,
  parameter logic [bstap_pkg::ID_W-1:0] ID_WORD = bstap_pkg::ID_WORD_DEF
) (
  // system clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // test pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  // boundary ring
  input wire logic [BSR_LEN-1:0] BSR_CAPTURE,
  output logic [BSR_LEN-1:0] BSR_OUT,
  output logic EXTEST_MODE,
  output logic OUT_HIGHZ
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // all three pins share the same latency so TMS/TDI line up with TCK
  // test clock resets to its parked low level, so no false fall follows
  bstap_sync #(.W(3), .RST_VAL(3'h6)) u_sync (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .pin_in({TDI, TMS, TCK}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  wire tck_rise = pin_rise[0];
  wire tck_fall = pin_fall[0];
  wire tms = pin_level[1];
  wire tdi = pin_level[2];

  // ****************************************************************
  // controller
  // ****************************************************************
  function automatic bstap_pkg::bstap_state_t next_state(
    input bstap_pkg::bstap_state_t s,
    input logic m
  );
    case (s)
      bstap_pkg::ST_RESET:
        next_state = m ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_IDLE:
        next_state = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_DR:
        next_state = m ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAP_DR;
      bstap_pkg::ST_CAP_DR:
        next_state = m ? bstap_pkg::ST_EX1_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_SH_DR:
        next_state = m ? bstap_pkg::ST_EX1_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_EX1_DR:
        next_state = m ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PAU_DR;
      bstap_pkg::ST_PAU_DR:
        next_state = m ? bstap_pkg::ST_EX2_DR : bstap_pkg::ST_PAU_DR;
      bstap_pkg::ST_EX2_DR:
        next_state = m ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_UPD_DR:
        next_state = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_IR:
        next_state = m ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAP_IR;
      bstap_pkg::ST_CAP_IR:
        next_state = m ? bstap_pkg::ST_EX1_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_SH_IR:
        next_state = m ? bstap_pkg::ST_EX1_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_EX1_IR:
        next_state = m ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_PAU_IR;
      bstap_pkg::ST_PAU_IR:
        next_state = m ? bstap_pkg::ST_EX2_IR : bstap_pkg::ST_PAU_IR;
      bstap_pkg::ST_EX2_IR:
        next_state = m ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_UPD_IR:
        next_state = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      default:
        next_state = bstap_pkg::ST_RESET;
    endcase
  endfunction : next_state

  bstap_pkg::bstap_state_t state_ff;
  bstap_pkg::bstap_state_t nxt_state;

  assign nxt_state = tck_rise ? next_state(state_ff, tms) : state_ff;

  // power-up reset lands in test-logic-reset; memory side is untouched
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_ff <= bstap_pkg::ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // instruction decode
  // ****************************************************************
  logic [bstap_pkg::IR_W-1:0] ir_ff;
  logic [bstap_pkg::IR_W-1:0] ir_sr_ff;
  logic [bstap_pkg::ID_W-1:0] id_sr_ff;
  logic [BSR_LEN-1:0] bsr_sr_ff;
  logic byp_ff;

  wire sel_id = (ir_ff == bstap_pkg::INS_IDCODE);
  wire sel_bsr = (ir_ff == bstap_pkg::INS_EXTEST) ||
                 (ir_ff == bstap_pkg::INS_SAMPLE_Z) ||
                 (ir_ff == bstap_pkg::INS_SAMPLE);
  // reserved codes are treated as bypass so the chain stays one bit
  wire sel_byp = !sel_id && !sel_bsr;

  wire in_sh_dr = (state_ff == bstap_pkg::ST_SH_DR);
  wire in_sh_ir = (state_ff == bstap_pkg::ST_SH_IR);
  wire is_shift = in_sh_dr || in_sh_ir;
  wire dr_lsb = sel_id ? id_sr_ff[0] :
                sel_bsr ? bsr_sr_ff[0] : byp_ff;
  wire scan_lsb = in_sh_ir ? ir_sr_ff[0] : dr_lsb;

  // ****************************************************************
  // instruction register
  // ****************************************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ir_ff <= bstap_pkg::INS_IDCODE;
      ir_sr_ff <= bstap_pkg::INS_IDCODE;
    end else if (tck_rise) begin
      // load on entry so no test instruction lingers in reset
      if (nxt_state == bstap_pkg::ST_RESET) begin
        ir_ff <= bstap_pkg::INS_IDCODE;
      end else if (state_ff == bstap_pkg::ST_CAP_IR) begin
        ir_sr_ff <= {1'b0, bstap_pkg::IR_CAPTURE_PAT};
      end else if (in_sh_ir) begin
        ir_sr_ff <= {tdi, ir_sr_ff[bstap_pkg::IR_W-1:1]};
      end else if (state_ff == bstap_pkg::ST_UPD_IR) begin
        ir_ff <= ir_sr_ff;
      end
    end
  end

  // ****************************************************************
  // data registers
  // ****************************************************************
  wire dr_cap = tck_rise && (state_ff == bstap_pkg::ST_CAP_DR);
  wire dr_sh = tck_rise && in_sh_dr;
  wire dr_upd = tck_rise && (state_ff == bstap_pkg::ST_UPD_DR);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      id_sr_ff <= '0;
      bsr_sr_ff <= '0;
      byp_ff <= 1'b0;
    end else if (dr_cap) begin
      if (sel_id) id_sr_ff <= ID_WORD;
      if (sel_bsr) bsr_sr_ff <= BSR_CAPTURE;
      if (sel_byp) byp_ff <= 1'b0;
    end else if (dr_sh) begin
      if (sel_id) id_sr_ff <= {tdi, id_sr_ff[bstap_pkg::ID_W-1:1]};
      if (sel_bsr) bsr_sr_ff <= {tdi, bsr_sr_ff[BSR_LEN-1:1]};
      if (sel_byp) byp_ff <= tdi;
    end
  end

  // update latch only moves at update-DR so the ring never sees shifting
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      BSR_OUT <= '0;
    end else if (dr_upd && sel_bsr) begin
      BSR_OUT <= bsr_sr_ff;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      EXTEST_MODE <= 1'b0;
      OUT_HIGHZ <= 1'b0;
    end else begin
      EXTEST_MODE <= (ir_ff == bstap_pkg::INS_EXTEST);
      OUT_HIGHZ <= (ir_ff == bstap_pkg::INS_SAMPLE_Z);
    end
  end

  // ****************************************************************
  // serial output, falling edge
  // ****************************************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO <= scan_lsb;
      TDO_OE <= is_shift;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [2:0] tms_run_ff;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tms_run_ff <= 3'h0;
    end else if (tck_rise) begin
      if (!tms) tms_run_ff <= 3'h0;
      else if (tms_run_ff != 3'h7) tms_run_ff <= tms_run_ff + 3'h1;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_five_tms: assert property (
    tms_run_ff >= 3'(bstap_pkg::TMS_RESET_EDGES) |->
      state_ff == bstap_pkg::ST_RESET)
    else $error("five high mode-select edges did not reset");
  a_step_rise: assert property (!tck_rise |=> $stable(state_ff))
    else $error("controller moved without a test-clock rise");
  a_tdo_fall: assert property (
    !tck_fall |=> $stable(TDO) && $stable(TDO_OE))
    else $error("serial output changed off the falling edge");
  a_oe_shift: assert property (tck_fall |=> TDO_OE == $past(is_shift))
    else $error("output enable disagrees with shift state");
  a_cap_ir: assert property (
    tck_rise && state_ff == bstap_pkg::ST_CAP_IR |=>
      ir_sr_ff[1:0] == bstap_pkg::IR_CAPTURE_PAT)
    else $error("capture-IR pattern wrong");
  a_msb_in: assert property (
    tck_rise && in_sh_ir |=> ir_sr_ff[bstap_pkg::IR_W-1] == $past(tdi))
    else $error("serial input not in MSB");
  a_lsb_out: assert property (
    tck_fall && in_sh_ir |=> TDO == $past(ir_sr_ff[0]))
    else $error("serial output not from LSB");
  a_byp_sel: assert property (
    tck_fall && in_sh_dr && sel_byp |=> TDO == $past(byp_ff))
    else $error("bypass not in scan path");
  a_reset_ir: assert property (
    tck_rise && nxt_state == bstap_pkg::ST_RESET |=>
      ir_ff == bstap_pkg::INS_IDCODE)
    else $error("reset did not load identification code");
  // holds after power-up and after a mode-select reset alike
  a_out_off: assert property (
    state_ff == bstap_pkg::ST_RESET |-> !TDO_OE)
    else $error("output enabled in reset state");

  c_id_shift: cover property (in_sh_dr && sel_id && tck_rise);
  c_upd_ir: cover property (tck_rise && state_ff == bstap_pkg::ST_UPD_IR);
  c_tms_reset: cover property (tms_run_ff == 3'h5);
  c_bsr_upd: cover property (dr_upd && sel_bsr);

endmodule : bstap_port

// >>> pkg/bstap_pkg.sv
package bstap_pkg;

  // ****************************************************************
  // register sizes and fixed patterns
  // ****************************************************************
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN_DEF = 16;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  localparam int TMS_RESET_EDGES = 5;

  // ****************************************************************
  // instruction codes, three reserved codes fall back to bypass
  // ****************************************************************
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

  // identification word; value is arbitrary
  localparam logic [ID_W-1:0] ID_WORD_DEF = 32'h1234_5679;

  // ****************************************************************
  // controller states
  // ****************************************************************
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001,
    ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008,
    ST_SH_DR   = 16'h0010,
    ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040,
    ST_EX2_DR  = 16'h0080,
    ST_UPD_DR  = 16'h0100,
    ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400,
    ST_SH_IR   = 16'h0800,
    ST_EX1_IR  = 16'h1000,
    ST_PAU_IR  = 16'h2000,
    ST_EX2_IR  = 16'h4000,
    ST_UPD_IR  = 16'h8000
  } bstap_state_t;

endpackage : bstap_pkg

// >>> rtl/bstap_sync.sv
`timescale 1ns/1ns
module bstap_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // pin levels
  input wire logic [W-1:0] pin_in,
  // synchronised level and edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // reset value high mirrors the pin pull-ups: an open pin reads one
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
      prev_ff <= RST_VAL;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

endmodule : bstap_sync

// >>> testbench/bstap_master.sv
`timescale 1ns/1ns
module bstap_master (
  // system clock
  input wire logic clk,
  // test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic drive_en = 1'b0;
  logic tms_v = 1'b1;
  logic tdi_v = 1'b1;

  // released pins float to the pull-up level
  assign tms = drive_en ? tms_v : 1'b1;
  assign tdi = drive_en ? tdi_v : 1'b1;

  initial begin
    tck = 1'b0;
  end

  // ********
  // one 80 ns test-clock period, called at a falling system edge
  // ********
  task automatic step(input logic ms, input logic di, output logic q,
                      output logic oe);
    drive_en = 1'b1;
    tms_v = ms;
    tdi_v = di;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    // a disabled output has no pull: show the inverse of the last bit
    q = tdo_oe ? tdo : ~tdo;
    oe = tdo_oe;
    repeat (4) @(negedge clk);
    tck = 1'b0;
  endtask : step

  // clock stays parked low between frames
  task automatic park();
    drive_en = 1'b0;
  endtask : park
endmodule : bstap_master

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int BL = 16;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [BL-1:0] bsr_cap = '0;
  logic tck, tms, tdi, tdo, tdo_oe, extest_mode, out_highz;
  logic [BL-1:0] bsr_out;
  int miscompares = 0;
  int checks_done = 0;

  bstap_port #(.BSR_LEN(BL)) dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .BSR_CAPTURE(bsr_cap), .BSR_OUT(bsr_out),
    .EXTEST_MODE(extest_mode), .OUT_HIGHZ(out_highz)
  );
  bstap_master m (
    .clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ********
  // checking helpers
  // ********
  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h vs %h", $time, what, got, exp);
    end
  endtask : cmp_vec

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %b vs %b", $time, what, got, exp);
    end
  endtask : cmp_flag

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // n high mode-select periods, then one low to reach idle
  task automatic tap_reset(input int n);
    logic q, oe;
    repeat (n) m.step(1'b1, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
  endtask : tap_reset

  // idle to idle scan; bits go out and come back lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q, oe;
    m.step(1'b1, 1'b1, q, oe);
    if (ir) m.step(1'b1, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      m.step(1'(i == n - 1), din[i], q, oe);
      dout[i] = q;
      cmp_flag(oe, 1'b1, "oe in shift");
    end
    m.step(1'b1, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    cmp_flag(oe, 1'b0, "oe in idle");
    m.park();
  endtask : scan

  // ********
  // scenarios
  // ********
  task automatic read_id();
    logic [31:0] d;
    scan(1'b0, 32, 32'hFFFF_FFFF, d);
    cmp_vec(d, bstap_pkg::ID_WORD_DEF, "id word");
  endtask : read_id

  task automatic t_power_up();
    cmp_flag(tdo_oe, 1'b0, "oe after reset");
    cmp_flag(extest_mode, 1'b0, "extest after reset");
    cmp_flag(out_highz, 1'b0, "highz after reset");
    cmp_vec(32'(bsr_out), 32'h0000_0000, "bsr after reset");
    tap_reset(0);
    read_id();
  endtask : t_power_up

  task automatic t_bypass();
    logic [31:0] d;
    logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, bstap_pkg::INS_BYPASS};
    scan(1'b1, 3, 32'h0000_0007, d);
    cmp_vec(d, 32'h0000_0001, "ir capture");
    foreach (codes[k]) begin
      scan(1'b1, 3, 32'(codes[k]), d);
      scan(1'b0, 4, 32'h0000_000D, d);
      cmp_vec(d, 32'h0000_000A, "bypass path");
    end
  endtask : t_bypass

  task automatic t_boundary();
    logic [31:0] d;
    logic [2:0] codes [3] = '{bstap_pkg::INS_SAMPLE,
      bstap_pkg::INS_EXTEST, bstap_pkg::INS_SAMPLE_Z};
    foreach (codes[k]) begin
      scan(1'b1, 3, 32'(codes[k]), d);
      cmp_flag(extest_mode, 1'(k == 1), "extest flag");
      cmp_flag(out_highz, 1'(k == 2), "highz flag");
      bsr_cap = 16'hA5C3 + 16'(k);
      scan(1'b0, BL, 32'h0000_3C5A + 32'(k), d);
      cmp_vec(d, 32'(bsr_cap), "ring capture");
      cmp_vec(32'(bsr_out), 32'h0000_3C5A + 32'(k), "ring update");
    end
  endtask : t_boundary

  // from shift-DR four highs stop short of reset, the fifth gets there
  task automatic t_tms_reset();
    logic [31:0] d;
    logic q, oe;
    scan(1'b1, 3, 32'(bstap_pkg::INS_EXTEST), d);
    m.step(1'b1, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    repeat (4) m.step(1'b1, 1'b1, q, oe);
    cmp_flag(extest_mode, 1'b1, "four highs");
    m.step(1'b1, 1'b1, q, oe);
    cmp_flag(extest_mode, 1'b0, "five highs");
    tap_reset(0);
    read_id();
  endtask : t_tms_reset

  // shift-DR split by a pause; the id word must still come out whole
  task automatic t_pause();
    logic [31:0] d;
    logic q, oe;
    d = '0;
    m.step(1'b1, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < 32; i++) begin
      m.step(1'(i == 15 || i == 31), 1'b1, q, oe);
      d[i] = q;
      cmp_flag(oe, 1'b1, "oe around pause");
      if (i == 15) begin
        m.step(1'b0, 1'b1, q, oe);
        m.step(1'b0, 1'b1, q, oe);
        cmp_flag(oe, 1'b0, "oe in pause");
        m.step(1'b1, 1'b1, q, oe);
        m.step(1'b0, 1'b1, q, oe);
      end
    end
    m.step(1'b1, 1'b1, q, oe);
    m.step(1'b0, 1'b1, q, oe);
    m.park();
    cmp_vec(d, bstap_pkg::ID_WORD_DEF, "id across pause");
  endtask : t_pause

  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_power_up();
    t_bypass();
    t_boundary();
    t_tms_reset();
    t_pause();
    stop_test();
  end

  // whole run needs well under 100 us of test clocks
  initial begin
    #200_000;
    miscompares++;
    stop_test();
  end
endmodule : testbench
